// [src/weight_filter.sv]
// Contract
// - each stage averages a chosen count of readings, one to 256.
// - three separately configured stages in cascade, each fed by the previous.
// - each stage passes a rolling average to the next stage.
// - with all lengths one and vibration cancel off, readings pass through unchanged.
// - one output per input reading; only settling time varies.
// - a cutout skips averaging and the output jumps to the new reading.
// - count consecutive out-of-band readings; cut out when count reaches sensitivity.
// - band width is display divisions around the current filtered value.
// - band setting none never suspends averaging.
// - vibration cancel removes a repeating vibration frequency before display.
// - stage lengths are powers of two from 1 to 256, default 4.
// - sensitivity is 2 to 128 in doubling steps, default 2.
// - band is none, 2, 5, 10, 20, 50, 100, 200 or 250 divisions.
`include "filt_defs.svh"

module weight_filter
    import filt_pkg::*;
(
    input  wire logic              ref_clk,      // 250 MHz clock
    input  wire logic              sys_rst,      // async reset, active high
    input  wire logic [`AXI_AW-1:0] awaddr,      // write address
    input  wire logic              awvalid,      // write address valid
    output logic                   awready,      // write address taken
    input  wire logic [31:0]       wdata,        // write data
    input  wire logic [3:0]        wstrb,        // write byte lanes
    input  wire logic              wvalid,       // write data valid
    output logic                   wready,       // write data taken
    output logic [1:0]             bresp,        // write answer code
    output logic                   bvalid,       // write answer valid
    input  wire logic              bready,       // write answer taken
    input  wire logic [`AXI_AW-1:0] araddr,      // read address
    input  wire logic              arvalid,      // read address valid
    output logic                   arready,      // read address taken
    output logic [31:0]            rdata,        // read data
    output logic [1:0]             rresp,        // read answer code
    output logic                   rvalid,       // read answer valid
    input  wire logic              rready,       // read answer taken
    input  wire logic              sample_valid, // a/d reading strobe
    input  wire sample_t           sample_data,  // a/d reading
    output logic                   weight_valid, // filtered weight strobe
    output sample_t                weight_data,  // filtered weight
    output logic                   cutout_pulse  // averaging bypassed
);
    chan_state_e wr_state_reg;
    chan_state_e rd_state_reg;
    logic [31:0] cfg_reg;
    logic [3:0]  vib_dly_reg;
    logic [15:0] div_reg;
    logic [1:0]  bresp_reg;
    logic [7:0]  oob_cnt_reg;
    logic        cfg_reseed_reg;
    logic        cutout_reg;
    logic [3:0]  quiet_reg;
    logic        wr_go;
    logic        rd_go;
    logic [31:0] cfg_next;
    logic [31:0] rd_word;
    logic        rd_ok;
    len_t        len1;
    len_t        len2;
    len_t        len3;
    logic [2:0]  sens_code;
    logic [3:0]  band_code;
    logic        vib_en;
    logic        vib_valid;
    sample_t     vib_data;
    logic [23:0] band_limit;
    logic [7:0]  sens_limit;
    logic        out_of_band;
    logic        cutout_fire;
    logic        reseed;
    sample_t     seed;
    logic        s1_valid;
    sample_t     s1_data;
    logic        s2_valid;
    sample_t     s2_data;

    // band width in divisions per setting code
    function automatic logic [7:0] band_divs(input logic [3:0] code);
        unique case (code)
            4'h1: return 8'h02;
            4'h2: return 8'h05;
            4'h3: return 8'h0A;
            4'h4: return 8'h14;
            4'h5: return 8'h32;
            4'h6: return 8'h64;
            4'h7: return 8'hC8;
            4'h8: return 8'hFA;
            default: return 8'h00;
        endcase
    endfunction

    // byte-lane merge of a write into a word
    function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) m[b*8 +: 8] = strb[b] ? new_w[b*8 +: 8] : old_w[b*8 +: 8];
        return m;
    endfunction

    // clamp illegal codes so only documented settings exist
    function automatic logic [31:0] legalize(input logic [31:0] v);
        logic [31:0] r;
        r = v & `CFG_MASK;
        if (r[`S1_LSB +: `LEN_W] > `LEN_MAX) r[`S1_LSB +: `LEN_W] = `LEN_MAX;
        if (r[`S2_LSB +: `LEN_W] > `LEN_MAX) r[`S2_LSB +: `LEN_W] = `LEN_MAX;
        if (r[`S3_LSB +: `LEN_W] > `LEN_MAX) r[`S3_LSB +: `LEN_W] = `LEN_MAX;
        if (r[`SENS_LSB +: `SENS_W] > `SENS_MAX) r[`SENS_LSB +: `SENS_W] = `SENS_MAX;
        if (r[`BAND_LSB +: `BAND_W] > `BAND_MAX) r[`BAND_LSB +: `BAND_W] = `BAND_MAX;
        return r;
    endfunction

    // config fields
    assign len1      = cfg_reg[`S1_LSB +: `LEN_W];
    assign len2      = cfg_reg[`S2_LSB +: `LEN_W];
    assign len3      = cfg_reg[`S3_LSB +: `LEN_W];
    assign sens_code = cfg_reg[`SENS_LSB +: `SENS_W];
    assign band_code = cfg_reg[`BAND_LSB +: `BAND_W];
    assign vib_en    = cfg_reg[`VIB_BIT];
    assign cfg_next  = legalize(merge(cfg_reg, wdata, wstrb));

    // write channel: address and data taken together, one at a time
    assign wr_go   = awvalid && wvalid && (wr_state_reg == CH_IDLE);
    assign awready = wr_go;
    assign wready  = wr_go;
    assign bvalid  = (wr_state_reg == CH_RESP);
    assign bresp   = bresp_reg;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_state_reg <= CH_IDLE;
            bresp_reg    <= `RESP_OKAY;
        end else begin
            unique case (wr_state_reg)
                CH_IDLE: begin
                    if (wr_go) begin
                        wr_state_reg <= CH_RESP;
                        bresp_reg    <= (awaddr[`AXI_AW-1:2] > `REG_WEIGHT >> 2) ?
                                        `RESP_SLVERR : `RESP_OKAY;
                    end
                end
                CH_RESP: begin
                    if (bready) wr_state_reg <= CH_IDLE;
                end
            endcase
        end
    end

    // writable registers; a config write restarts averaging from the shown value
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_reg        <= `CFG_RESET;
            vib_dly_reg    <= `VIB_RESET;
            div_reg        <= `DIV_RESET;
            cfg_reseed_reg <= 1'b0;
        end else begin
            cfg_reseed_reg <= 1'b0;
            if (wr_go) begin
                unique case ({awaddr[`AXI_AW-1:2], 2'b00})
                    `REG_CONFIG: begin
                        cfg_reg        <= cfg_next;
                        cfg_reseed_reg <= 1'b1;
                    end
                    `REG_VIB: begin
                        if (wstrb[0]) vib_dly_reg <= wdata[3:0];
                    end
                    `REG_DIV: begin
                        div_reg <= 16'(merge({16'h0000, div_reg}, wdata, wstrb));
                    end
                    default: ;
                endcase
            end
        end
    end

    // read channel
    always_comb begin
        rd_word = '0;
        rd_ok   = 1'b1;
        unique case ({araddr[`AXI_AW-1:2], 2'b00})
            `REG_CONFIG: rd_word = cfg_reg;
            `REG_VIB:    rd_word = {28'h000_0000, vib_dly_reg};
            `REG_DIV:    rd_word = {16'h0000, div_reg};
            `REG_STATUS: rd_word = {23'h00_0000, cutout_reg, oob_cnt_reg};
            `REG_WEIGHT: rd_word = 32'(weight_data);
            default:     rd_ok   = 1'b0;
        endcase
    end

    assign rd_go   = arvalid && (rd_state_reg == CH_IDLE);
    assign arready = (rd_state_reg == CH_IDLE);
    assign rvalid  = (rd_state_reg == CH_RESP);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_state_reg <= CH_IDLE;
            rdata        <= '0;
            rresp        <= `RESP_OKAY;
        end else begin
            unique case (rd_state_reg)
                CH_IDLE: begin
                    if (rd_go) begin
                        rd_state_reg <= CH_RESP;
                        rdata        <= rd_word;
                        rresp        <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
                    end
                end
                CH_RESP: begin
                    if (rready) rd_state_reg <= CH_IDLE;
                end
            endcase
        end
    end

    // vibration cancel ahead of the averaging stages
    vib_cancel u_vib (
        .clk       (ref_clk),
        .rst       (sys_rst),
        .enable    (vib_en),
        .delay_sel (vib_dly_reg),
        .in_valid  (sample_valid),
        .in_data   (sample_data),
        .out_valid (vib_valid),
        .out_data  (vib_data)
    );

    // band in raw counts, centred on the shown weight
    // widen both factors first so a wide band never wraps at 16 bits
    assign band_limit  = 24'(band_divs(band_code)) * 24'(div_reg);
    assign sens_limit  = 8'h02 << sens_code;
    assign out_of_band = (vib_data > weight_data) ?
                         (25'(vib_data) - 25'(weight_data) > 25'(band_limit)) :
                         (25'(weight_data) - 25'(vib_data) > 25'(band_limit));
    // setting none disables the override entirely
    assign cutout_fire = vib_valid && out_of_band && (band_code != 4'h0)
                         && (oob_cnt_reg == sens_limit - 8'h01);
    // cutout seed wins over a config restart in the same cycle
    assign reseed = cutout_fire || cfg_reseed_reg;
    assign seed   = cutout_fire ? vib_data : weight_data;

    // consecutive out-of-band counter
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            oob_cnt_reg <= '0;
        end else if (vib_valid) begin
            if (!out_of_band || band_code == 4'h0 || cutout_fire) begin
                oob_cnt_reg <= '0;
            end else begin
                oob_cnt_reg <= oob_cnt_reg + 8'h01;
            end
        end
    end

    // cutout status for software and the outside
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cutout_reg <= 1'b0;
        end else if (vib_valid) begin
            cutout_reg <= cutout_fire;
        end
    end
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cutout_pulse <= 1'b0;
        end else begin
            cutout_pulse <= cutout_fire;
        end
    end

    // three cascaded stages; all reseeded together so the jump is clean
    avg_stage u_stage1 (
        .clk       (ref_clk),
        .rst       (sys_rst),
        .in_valid  (vib_valid),
        .in_data   (vib_data),
        .len_log2  (len1),
        .reseed    (reseed),
        .seed      (seed),
        .out_valid (s1_valid),
        .out_data  (s1_data)
    );
    avg_stage u_stage2 (
        .clk       (ref_clk),
        .rst       (sys_rst),
        .in_valid  (s1_valid),
        .in_data   (s1_data),
        .len_log2  (len2),
        .reseed    (reseed),
        .seed      (seed),
        .out_valid (s2_valid),
        .out_data  (s2_data)
    );
    avg_stage u_stage3 (
        .clk       (ref_clk),
        .rst       (sys_rst),
        .in_valid  (s2_valid),
        .in_data   (s2_data),
        .len_log2  (len3),
        .reseed    (reseed),
        .seed      (seed),
        .out_valid (weight_valid),
        .out_data  (weight_data)
    );

    // cycles since last register write, held at 8, for the checks only
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            quiet_reg <= '0;
        end else if (wr_go) begin
            quiet_reg <= '0;
        end else if (quiet_reg != `QUIET_CYC) begin
            quiet_reg <= quiet_reg + 4'h1;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    chk_rate_kept: assert property (sample_valid |-> ##4 weight_valid)
        else $error("reading did not yield an output four cycles on");
    chk_no_extra: assert property (weight_valid |-> $past(sample_valid, 4))
        else $error("output without a matching reading");
    chk_pass_plain: assert property ((weight_valid && len1 == '0 && len2 == '0
        && len3 == '0 && !vib_en && quiet_reg == `QUIET_CYC)
        |-> weight_data == $past(sample_data, 4))
        else $error("unit lengths changed the reading");
    chk_cutout_jump: assert property ((cutout_fire ##1 (!reseed)[*2])
        |=> weight_data == $past(vib_data, 3))
        else $error("cutout did not jump to the new reading");
    chk_count_gate: assert property (cutout_fire |-> oob_cnt_reg + 8'h01 == sens_limit)
        else $error("cutout before the consecutive count");
    chk_count_clear: assert property ((vib_valid && !out_of_band) |=> oob_cnt_reg == '0)
        else $error("in-band reading left the counter");
    chk_none_band: assert property (band_code == 4'h0 |-> !cutout_fire)
        else $error("cutout with band setting none");
    chk_codes_legal: assert property (len1 <= `LEN_MAX && len2 <= `LEN_MAX
        && len3 <= `LEN_MAX && sens_code <= `SENS_MAX && band_code <= `BAND_MAX)
        else $error("illegal setting code stored");
    chk_bresp_hold: assert property ((bvalid && !bready) |=> bvalid && $stable(bresp))
        else $error("write answer dropped early");

    cov_cutout: cover property (cutout_fire);
    cov_long_run: cover property (vib_valid && oob_cnt_reg == 8'h7F);
    cov_vib_on: cover property (vib_en && weight_valid);
endmodule

// [src/filt_defs.svh]
`ifndef FILT_DEFS_SVH
`define FILT_DEFS_SVH

// data path widths
`define SAMPLE_W    24
`define ACC_W       32
`define LEN_W       4
`define PTR_W       8
`define HIST_DEPTH  256
`define VIB_DEPTH   16
`define AXI_AW      8

// register byte offsets
`define REG_CONFIG  8'h00
`define REG_VIB     8'h04
`define REG_DIV     8'h08
`define REG_STATUS  8'h0C
`define REG_WEIGHT  8'h10

// config field positions
`define S1_LSB      0
`define S2_LSB      4
`define S3_LSB      8
`define SENS_LSB    12
`define SENS_W      3
`define BAND_LSB    16
`define BAND_W      4
`define VIB_BIT     24

// reset values and limits
`define CFG_RESET   32'h0000_0222
`define CFG_MASK    32'h010F_7FFF
`define LEN_MAX     4'h8
`define SENS_MAX    3'h6
`define BAND_MAX    4'h8
`define VIB_RESET   4'h7
`define DIV_RESET   16'h0001
`define QUIET_CYC   4'h8

// bus answers
`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10

`endif

// [src/filt_pkg.sv]
`include "filt_defs.svh"

package filt_pkg;
    typedef logic signed [`SAMPLE_W-1:0] sample_t;
    typedef logic signed [`ACC_W-1:0]    acc_t;
    typedef logic [`LEN_W-1:0]           len_t;
    typedef logic [`PTR_W-1:0]           ptr_t;
    typedef enum logic {CH_IDLE = 1'b0, CH_RESP = 1'b1} chan_state_e;

    // sign extension into the accumulator
    function automatic acc_t widen(input sample_t v);
        return acc_t'(v);
    endfunction
endpackage

// [src/avg_stage.sv]
`include "filt_defs.svh"

module avg_stage
    import filt_pkg::*;
(
    input  wire logic    clk,       // filter clock
    input  wire logic    rst,       // async reset, active high
    input  wire logic    in_valid,  // reading from the stage ahead
    input  wire sample_t in_data,   // that reading
    input  wire len_t    len_log2,  // window length as a power of two
    input  wire logic    reseed,    // load every history slot with seed
    input  wire sample_t seed,      // value used by reseed
    output logic         out_valid, // rolling average ready
    output sample_t      out_data   // rolling average
);
    sample_t hist_reg [`HIST_DEPTH];
    acc_t    sum_reg;
    acc_t    sum_next;
    ptr_t    ptr_reg;
    ptr_t    mask;

    // window wraps at the configured length; slots above stay unused
    assign mask = ptr_t'((9'h001 << len_log2) - 9'h001);
    // running sum: newest in, oldest out
    assign sum_next = sum_reg + widen(in_data) - widen(hist_reg[ptr_reg]);

    // history ring
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `HIST_DEPTH; i++) hist_reg[i] <= '0;
        end else if (reseed) begin
            for (int i = 0; i < `HIST_DEPTH; i++) hist_reg[i] <= seed;
        end else if (in_valid) begin
            hist_reg[ptr_reg] <= in_data;
        end
    end

    // sum and write pointer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sum_reg <= '0;
            ptr_reg <= '0;
        end else if (reseed) begin
            sum_reg <= widen(seed) <<< len_log2;
            ptr_reg <= '0;
        end else if (in_valid) begin
            sum_reg <= sum_next;
            ptr_reg <= (ptr_reg + 8'h01) & mask;
        end
    end

    // average out, one per reading in; divide is a shift
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            out_valid <= in_valid;
            if (reseed) begin
                out_data <= seed;
            end else if (in_valid) begin
                out_data <= sample_t'(sum_next >>> len_log2);
            end
        end
    end

    chk_unity_pass: assert property (@(posedge clk) disable iff (rst)
        (in_valid && !reseed && len_log2 == '0) |=> out_data == $past(in_data))
        else $error("length one stage altered its reading");
endmodule

// [src/vib_cancel.sv]
`include "filt_defs.svh"

module vib_cancel
    import filt_pkg::*;
(
    input  wire logic       clk,       // filter clock
    input  wire logic       rst,       // async reset, active high
    input  wire logic       enable,    // vibration_cancel_enable
    input  wire logic [3:0] delay_sel, // comb delay minus one
    input  wire logic       in_valid,  // raw reading strobe
    input  wire sample_t    in_data,   // raw reading
    output logic            out_valid, // cleaned reading strobe
    output sample_t         out_data   // cleaned reading
);
    sample_t                   dline_reg [`VIB_DEPTH];
    sample_t                   past;
    logic signed [`SAMPLE_W:0] pair_sum;

    // averaging with a copy delayed by half a period nulls that tone
    assign past     = dline_reg[delay_sel];
    assign pair_sum = {in_data[`SAMPLE_W-1], in_data} + {past[`SAMPLE_W-1], past};

    // delay line of earlier readings
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `VIB_DEPTH; i++) dline_reg[i] <= '0;
        end else if (in_valid) begin
            dline_reg[0] <= in_data;
            for (int i = 1; i < `VIB_DEPTH; i++) dline_reg[i] <= dline_reg[i-1];
        end
    end

    // comb output; off means straight through
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                out_data <= enable ? pair_sum[`SAMPLE_W:1] : in_data;
            end
        end
    end
endmodule

// [tb/adc_model.sv]
module adc_model
    import filt_pkg::*;
(
    input  wire logic clk,          // filter clock
    output logic      sample_valid, // reading strobe
    output sample_t   sample_data   // reading
);
    timeunit 1ns;
    timeprecision 1ps;

    // quiet converter at time zero
    initial begin
        sample_valid = 1'b0;
        sample_data  = '0;
    end

    // one reading per call, launched just after an edge
    task automatic send(input sample_t v);
        @(posedge clk);
        sample_valid <= 1'b1;
        sample_data  <= v;
    endtask

    // no hold after the strobe: show the inverse so stale data never looks valid
    always @(posedge clk) begin
        if (sample_valid) begin
            sample_valid <= 1'b0;
            sample_data  <= ~sample_data;
        end
    end
endmodule

// [tb/weight_averaging_filter_cutout_tb.sv]
`include "filt_defs.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("FAIL %s exp %0h got %0h", nm, e, g); end end

module weight_averaging_filter_cutout_tb
    import filt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic               ref_clk, sys_rst;
    logic [`AXI_AW-1:0] awaddr, araddr;
    logic               awvalid, awready, wvalid, wready, bvalid, bready;
    logic               arvalid, arready, rvalid, rready;
    logic [31:0]        wdata, rdata;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp;
    logic               sample_valid, weight_valid, cutout_pulse;
    sample_t            sample_data, weight_data;
    int                 bad_count, cmp_count;

    weight_filter uut (.ref_clk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .sample_valid, .sample_data, .weight_valid,
        .weight_data, .cutout_pulse);

    adc_model adc (.clk(ref_clk), .sample_valid, .sample_data);

    // 250 MHz
    always #2 ref_clk = ~ref_clk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // bounded wait for a handshake, sampled well clear of the edge
    task automatic waitfor(const ref logic s);
        int n;
        n = 0;
        #1;
        while (s !== 1'b1) begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n > 40) begin
                bad_count++;
                $display("FAIL handshake exp 1 got 0");
                close_out();
            end
        end
    endtask

    // address and data offered together, answer held ready until seen
    task automatic wr(input logic [`AXI_AW-1:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        waitfor(awready);
        @(posedge ref_clk);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        waitfor(bvalid);
        `CHK("bresp", a > `REG_WEIGHT ? `RESP_SLVERR : `RESP_OKAY, bresp)
        @(posedge ref_clk);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [`AXI_AW-1:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge ref_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        waitfor(arready);
        @(posedge ref_clk);
        arvalid <= 1'b0;
        waitfor(rvalid);
        `CHK("rdata", e, rdata)
        `CHK("rresp", er, rresp)
        @(posedge ref_clk);
        rready <= 1'b0;
    endtask

    // one reading in, one weight out; chk off where history is unknown
    task automatic rdg(input sample_t v, input sample_t e, input logic cut, input logic chk);
        int   n;
        logic c;
        n = 0;
        c = 1'b0;
        adc.send(v);
        while (weight_valid !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            #1;
            n++;
            c = c | (cutout_pulse === 1'b1);
        end
        `CHK("latency", 4, n)
        if (n >= 20) close_out();
        if (chk) `CHK("weight", e, weight_data)
        `CHK("cutout", cut, c)
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic t_regs();
        rd(`REG_CONFIG, 32'h0000_0222, `RESP_OKAY);
        rd(`REG_VIB, 32'h0000_0007, `RESP_OKAY);
        rd(`REG_DIV, 32'h0000_0001, `RESP_OKAY);
        wr(`REG_CONFIG, 32'hFFFF_FFFF);
        rd(`REG_CONFIG, 32'h0108_6888, `RESP_OKAY);
        rd(8'h14, 32'h0000_0000, `RESP_SLVERR);
        wr(8'h14, 32'h0000_0000);
    endtask

    task automatic t_pass();
        wr(`REG_CONFIG, 32'h0000_0000);
        rdg(100, 100, 1'b0, 1'b1);
        rdg(-50, -50, 1'b0, 1'b1);
        rdg(7, 7, 1'b0, 1'b1);
    endtask

    // two-reading windows, then two stages chained
    task automatic t_avg();
        wr(`REG_CONFIG, 32'h0000_0001);
        rdg(21, 14, 1'b0, 1'b1);
        rdg(21, 21, 1'b0, 1'b1);
        wr(`REG_CONFIG, 32'h0000_0011);
        rdg(25, 22, 1'b0, 1'b1);
    endtask

    // band of 2 divisions, two in a row needed; edge of band stays in
    task automatic t_cut();
        wr(`REG_CONFIG, 32'h0001_0003);
        rdg(24, 22, 1'b0, 1'b1);
        rdg(1000, 144, 1'b0, 1'b1);
        rdg(1000, 1000, 1'b1, 1'b1);
        rdg(1000, 1000, 1'b0, 1'b1);
        rdg(1010, 1001, 1'b0, 1'b1);
        rdg(1001, 1001, 1'b0, 1'b1);
        rdg(5000, 1501, 1'b0, 1'b1);
    endtask

    task automatic t_none();
        wr(`REG_CONFIG, 32'h0000_0003);
        rdg(-2000, 1063, 1'b0, 1'b1);
        rdg(-2000, 625, 1'b0, 1'b1);
    endtask

    // comb delay of one reading halves each pair
    task automatic t_vib();
        wr(`REG_VIB, 32'h0000_0000);
        wr(`REG_CONFIG, 32'h0100_0000);
        rdg(100, -950, 1'b0, 1'b1);
        rdg(100, 100, 1'b0, 1'b1);
        rdg(300, 200, 1'b0, 1'b1);
        rd(`REG_WEIGHT, 32'h0000_00C8, `RESP_OKAY);
    endtask

    // four in a row needed, band 5 divisions of 5 counts; the third outlier must not cut
    task automatic t_sens();
        wr(`REG_DIV, 32'h0000_0005);
        wr(`REG_CONFIG, 32'h0002_1001);
        rdg(225, 212, 1'b0, 1'b1);
        rdg(300, 262, 1'b0, 1'b1);
        rdg(300, 300, 1'b0, 1'b1);
        rdg(400, 350, 1'b0, 1'b1);
        rdg(500, 500, 1'b1, 1'b1);
        rd(`REG_STATUS, 32'h0000_0100, `RESP_OKAY);
    endtask

    // reset for 16 cycles, then the scenarios in order
    initial begin
        ref_clk   = 1'b0;
        sys_rst   = 1'b1;
        awaddr    = '0;
        araddr    = '0;
        awvalid   = 1'b0;
        wvalid    = 1'b0;
        bready    = 1'b0;
        arvalid   = 1'b0;
        rready    = 1'b0;
        wdata     = '0;
        wstrb     = 4'hF;
        bad_count = 0;
        cmp_count = 0;
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_pass();
        t_avg();
        t_cut();
        t_none();
        t_vib();
        t_sens();
        close_out();
    end
endmodule
